// [design/elb_lane_steer.sv]
// Lane steering and bus-width sequencer between the processor load/store path and external memory.
// Assumes bank timing logic on clk_sys runs each external cycle and pulses ext_done at its end.
`timescale 1ns/1ps
module elb_lane_steer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Board straps
   input wire logic big_endian_strap,
   input wire logic [1:0] bank0_width_strap,
   // Processor request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [1:0] req_size,
   input wire logic req_bank0,
   input wire logic [1:0] bank_width,
   input wire logic [31:0] req_addr,
   input wire logic [31:0] req_wdata,
   // Processor response
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic rsp_write,
   output logic [31:0] rsp_rdata,
   // External cycle
   output logic ext_cyc,
   output logic ext_we_b,
   output logic [3:0] ext_be_b,
   output logic [31:0] ext_addr,
   output logic [31:0] ext_wdata,
   input wire logic ext_done,
   input wire logic [31:0] ext_rdata
);
   elb_pkg::elb_state_type state_ff;
   logic write_ff;
   logic [1:0] size_ff;
   logic [1:0] width_ff;
   logic [31:0] addr_ff;
   logic [31:0] wdata_ff;
   logic [31:0] ea_ff;
   logic [1:0] beats_ff;
   logic [1:0] rem_ff;
   logic [31:0] acc_ff;
   logic ext_cyc_ff;
   logic ext_we_b_ff;
   logic [3:0] ext_be_b_ff;
   logic [31:0] ext_addr_ff;
   logic [31:0] ext_wdata_ff;
   logic big_q;
   logic [1:0] strap_width;
   logic straps_ready;
   logic buf_in_ready;
   logic [elb_pkg::RSP_W-1:0] buf_out_data;

   // Beats minus one for a size on a bus width.
   function automatic logic [1:0] beats_m1(input logic [1:0] width, input logic [1:0] size);
      case (width)
         elb_pkg::BW_8: beats_m1 = (size == elb_pkg::SZ_WORD) ? elb_pkg::REM_THREE :
                                   (size == elb_pkg::SZ_HALF) ? elb_pkg::REM_ONE : elb_pkg::REM_ZERO;
         elb_pkg::BW_16: beats_m1 = (size == elb_pkg::SZ_WORD) ? elb_pkg::REM_ONE : elb_pkg::REM_ZERO;
         default: beats_m1 = elb_pkg::REM_ZERO;
      endcase
   endfunction

   // External unit address: bytes, halfwords or words depending on bus width.
   function automatic logic [31:0] ext_base(input logic [31:0] a, input logic [1:0] width);
      case (width)
         elb_pkg::BW_8: ext_base = a;
         elb_pkg::BW_16: ext_base = {1'b0, a[31:1]};
         default: ext_base = {2'b00, a[31:2]};
      endcase
   endfunction

   // Data driven for one beat; every enabled lane carries the right byte.
   function automatic logic [31:0] beat_wdata(input logic [31:0] r, input logic [1:0] size,
                                              input logic [1:0] width, input logic big, input logic [1:0] rem);
      logic [31:0] bus;
      logic [15:0] c16;
      logic [7:0] c8;
      bus = elb_pkg::repl(r, size);
      c16 = (size == elb_pkg::SZ_WORD) ? ((rem != elb_pkg::REM_ZERO) ? r[31:16] : r[15:0]) : bus[15:0];
      case (rem)
         2'h3: c8 = r[31:24];
         2'h2: c8 = r[23:16];
         2'h1: c8 = r[15:8];
         default: c8 = r[7:0];
      endcase
      case (width)
         elb_pkg::BW_8: beat_wdata = {4{c8}};
         elb_pkg::BW_16: beat_wdata = big ? {2{elb_pkg::swap16(c16)}} : {2{c16}};
         default: beat_wdata = big ? elb_pkg::swap32(bus) : bus;
      endcase
   endfunction

   // Active-low write strobes; loads assert none and take the whole bus.
   function automatic logic [3:0] beat_be(input logic write, input logic [1:0] size,
                                          input logic [1:0] width, input logic [1:0] lo);
      if (!write) begin
         beat_be = elb_pkg::BE_NONE_B;
      end else begin
         case (width)
            elb_pkg::BW_8: beat_be = elb_pkg::BE_LANE0_B;
            elb_pkg::BW_16: beat_be = (size != elb_pkg::SZ_BYTE) ? elb_pkg::BE_LO_B :
                                      (lo[0] ? elb_pkg::BE_LANE1_B : elb_pkg::BE_LANE0_B);
            default: begin
               case (size)
                  elb_pkg::SZ_WORD: beat_be = elb_pkg::BE_ALL_B;
                  elb_pkg::SZ_HALF: beat_be = lo[1] ? elb_pkg::BE_HI_B : elb_pkg::BE_LO_B;
                  default: beat_be = ~(elb_pkg::BE_ONE << lo);
               endcase
            end
         endcase
      end
   endfunction

   // Piece of the register value that one returned beat contributes, most significant first.
   function automatic logic [31:0] read_piece(input logic [31:0] ext, input logic [1:0] size,
                                              input logic [1:0] width, input logic big, input logic [1:0] lo);
      logic [15:0] h;
      logic [7:0] b;
      h = 16'h0000;
      b = 8'h00;
      read_piece = elb_pkg::WORD_ZERO;
      case (width)
         elb_pkg::BW_8: read_piece = {24'h00_0000, ext[7:0]};
         elb_pkg::BW_16: begin
            if (size == elb_pkg::SZ_BYTE) begin
               b = lo[0] ? ext[15:8] : ext[7:0];
               read_piece = {24'h00_0000, b};
            end else begin
               h = big ? elb_pkg::swap16(ext[15:0]) : ext[15:0];
               read_piece = {16'h0000, h};
            end
         end
         default: begin
            case (size)
               elb_pkg::SZ_WORD: read_piece = big ? elb_pkg::swap32(ext) : ext;
               elb_pkg::SZ_HALF: begin
                  h = lo[1] ? ext[31:16] : ext[15:0];
                  read_piece = {16'h0000, big ? elb_pkg::swap16(h) : h};
               end
               default: begin
                  b = ext[{lo, 3'b000} +: 8];
                  read_piece = {24'h00_0000, b};
               end
            endcase
         end
      endcase
   endfunction

   elb_strap_sample u_straps (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .big_endian_strap(big_endian_strap),
      .bank0_width_strap(bank0_width_strap),
      .big_endian(big_q),
      .bank0_width(strap_width),
      .straps_ready(straps_ready)
   );

   // Request decode.
   wire accept = req_valid && req_ready;
   wire [1:0] sel_width = req_bank0 ? strap_width : elb_pkg::norm_width(bank_width);
   wire word_class = (req_addr[1:0] == 2'h0);
   wire half_class = !req_addr[0];
   wire [31:0] aligned_addr = (req_size == elb_pkg::SZ_WORD) ? {req_addr[31:2], 2'b00} :
                              (req_size == elb_pkg::SZ_HALF) ? {req_addr[31:1], 1'b0} : req_addr;
   wire [1:0] new_beats = beats_m1(sel_width, req_size);

   // Beat sources: a fresh request on accept, otherwise the held one at the next beat.
   wire last_done = (state_ff == elb_pkg::ST_BEAT) && ext_done && (rem_ff == elb_pkg::REM_ZERO);
   wire next_beat = (state_ff == elb_pkg::ST_BEAT) && ext_done && (rem_ff != elb_pkg::REM_ZERO);
   wire b_write = accept ? req_write : write_ff;
   wire [1:0] b_size = accept ? req_size : size_ff;
   wire [1:0] b_width = accept ? sel_width : width_ff;
   wire [31:0] b_addr = accept ? aligned_addr : addr_ff;
   wire [31:0] b_wdata = accept ? req_wdata : wdata_ff;
   wire [31:0] b_ea = accept ? ext_base(aligned_addr, sel_width) : ea_ff;
   wire [1:0] b_beats = accept ? new_beats : beats_ff;
   wire [1:0] nxt_rem = accept ? new_beats : rem_ff - elb_pkg::REM_ONE;
   // Big-endian climbs from the base address; little-endian starts at the top and descends.
   wire [1:0] b_off = big_q ? (b_beats - nxt_rem) : nxt_rem;
   wire [31:0] nxt_ext_addr = b_ea + {30'h0000_0000, b_off};
   wire [31:0] nxt_ext_wdata = beat_wdata(b_wdata, b_size, b_width, big_q, nxt_rem);
   wire [3:0] nxt_ext_be_b = beat_be(b_write, b_size, b_width, b_addr[1:0]);

   // Load assembly shifts earlier beats up, so the first beat lands most significant.
   wire [31:0] piece = read_piece(ext_rdata, size_ff, width_ff, big_q, addr_ff[1:0]);
   wire [31:0] nxt_acc = (width_ff == elb_pkg::BW_8) ? ({acc_ff[23:0], 8'h00} | piece) :
                         (width_ff == elb_pkg::BW_16) ? ({acc_ff[15:0], 16'h0000} | piece) : piece;
   wire [31:0] rsp_word = write_ff ? elb_pkg::WORD_ZERO : elb_pkg::repl(acc_ff, size_ff);
   wire buf_in_valid = (state_ff == elb_pkg::ST_PUSH);
   wire [elb_pkg::RSP_W-1:0] buf_in_data = {write_ff, rsp_word};

   assign req_ready = (state_ff == elb_pkg::ST_IDLE) && straps_ready;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= elb_pkg::ST_IDLE;
      end else begin
         case (state_ff)
            elb_pkg::ST_IDLE: if (accept) state_ff <= elb_pkg::ST_BEAT;
            elb_pkg::ST_BEAT: if (last_done) state_ff <= elb_pkg::ST_PUSH;
            elb_pkg::ST_PUSH: if (buf_in_ready) state_ff <= elb_pkg::ST_IDLE;
            default: state_ff <= elb_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         write_ff <= 1'b0;
         size_ff <= elb_pkg::SZ_WORD;
         width_ff <= elb_pkg::BW_32;
         addr_ff <= elb_pkg::WORD_ZERO;
         wdata_ff <= elb_pkg::WORD_ZERO;
         ea_ff <= elb_pkg::WORD_ZERO;
         beats_ff <= elb_pkg::REM_ZERO;
      end else if (accept) begin
         write_ff <= req_write;
         size_ff <= req_size;
         width_ff <= sel_width;
         addr_ff <= aligned_addr;
         wdata_ff <= req_wdata;
         ea_ff <= ext_base(aligned_addr, sel_width);
         beats_ff <= new_beats;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rem_ff <= elb_pkg::REM_ZERO;
         ext_we_b_ff <= 1'b1;
         ext_be_b_ff <= elb_pkg::BE_NONE_B;
         ext_addr_ff <= elb_pkg::WORD_ZERO;
         ext_wdata_ff <= elb_pkg::WORD_ZERO;
      end else if (accept || next_beat) begin
         rem_ff <= nxt_rem;
         ext_we_b_ff <= !b_write;
         ext_be_b_ff <= nxt_ext_be_b;
         ext_addr_ff <= nxt_ext_addr;
         ext_wdata_ff <= nxt_ext_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ext_cyc_ff <= 1'b0;
         acc_ff <= elb_pkg::WORD_ZERO;
      end else begin
         if (accept) begin
            ext_cyc_ff <= 1'b1;
            acc_ff <= elb_pkg::WORD_ZERO;
         end else if ((state_ff == elb_pkg::ST_BEAT) && ext_done) begin
            ext_cyc_ff <= !last_done;
            acc_ff <= nxt_acc;
         end
      end
   end

   // A stalled processor fills this buffer, which holds the sequencer in its push state.
   elb_rsp_buf #(.WIDTH(elb_pkg::RSP_W)) u_rsp_buf (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(rsp_valid),
      .out_ready(rsp_ready),
      .out_data(buf_out_data)
   );

   assign rsp_write = buf_out_data[elb_pkg::RSP_W-1];
   assign rsp_rdata = buf_out_data[31:0];
   assign ext_cyc = ext_cyc_ff;
   assign ext_we_b = ext_we_b_ff;
   assign ext_be_b = ext_be_b_ff;
   assign ext_addr = ext_addr_ff;
   assign ext_wdata = ext_wdata_ff;

   a_done_after_last: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      $rose(buf_in_valid) |-> $past(ext_done && rem_ff == elb_pkg::REM_ZERO && ext_cyc_ff))
      else $error("Completion queued before the last external cycle ended.");

   a_byte_bus_beats: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      accept && req_size == elb_pkg::SZ_WORD && sel_width == elb_pkg::BW_8 |=> ext_cyc_ff && rem_ff == 2'h3)
      else $error("Word on byte bus did not start four beats.");

   a_big_ascend: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      next_beat && big_q |=> ext_addr_ff == $past(ext_addr_ff) + 32'h0000_0001)
      else $error("Big-endian beat address did not ascend.");

   a_little_descend: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      next_beat && !big_q |=> ext_addr_ff == $past(ext_addr_ff) - 32'h0000_0001)
      else $error("Little-endian beat address did not descend.");

   a_wide_single_beat: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      accept && sel_width == elb_pkg::BW_32 |=> rem_ff == elb_pkg::REM_ZERO ##1 ext_cyc_ff || $past(ext_done))
      else $error("Full-width access took more than one beat.");

   a_wide_word_store: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      ext_cyc_ff && width_ff == elb_pkg::BW_32 && !big_q && write_ff && size_ff == elb_pkg::SZ_WORD
      |-> ext_wdata_ff == wdata_ff && ext_be_b_ff == elb_pkg::BE_ALL_B)
      else $error("Little-endian word store altered on full-width bus.");

   a_half_bus_byte: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      ext_cyc_ff && width_ff == elb_pkg::BW_16 && !big_q && write_ff && size_ff == elb_pkg::SZ_BYTE
      |-> ext_be_b_ff == (addr_ff[0] ? elb_pkg::BE_LANE1_B : elb_pkg::BE_LANE0_B)
          && ext_wdata_ff[15:8] == wdata_ff[7:0] && ext_wdata_ff[7:0] == wdata_ff[7:0])
      else $error("Byte store on half-width bus used the wrong lane.");

   a_big_word_first: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      ext_cyc_ff && width_ff == elb_pkg::BW_16 && big_q && size_ff == elb_pkg::SZ_WORD && rem_ff == 2'h1
      |-> ext_addr_ff == ea_ff)
      else $error("Big-endian word on half-width bus did not start at base.");

   a_half_replicate: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      buf_in_valid && !write_ff && size_ff == elb_pkg::SZ_HALF |-> buf_in_data[31:16] == buf_in_data[15:0])
      else $error("Halfword load was not replicated on both halves.");

   a_word_class: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      accept && req_size == elb_pkg::SZ_WORD |=> addr_ff[1:0] == 2'h0)
      else $error("Word access not steered as word-aligned.");

   a_strap_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      straps_ready |=> $stable(big_q) && $stable(strap_width))
      else $error("Strap values changed after capture.");
endmodule

// [design/elb_pkg.sv]
// Constants, types and shared steering functions for the external bus lane steering block.
// Assumes the processor presents register data low-aligned and that straps are stable at reset.
// Behaviour
// - Byte order for all external accesses follows the endianness strap pin.
// - Bank 0 external bus width comes from the two-bit width strap.
// - Access size sets alignment: address low bits are cleared for words and halfwords; the remaining low bits steer lanes.
// - Big-endian word load, 16-bit bus: EA fills upper half, EA+1 lower.
// - Big-endian halfword or byte load, 16-bit bus: one access, replicated on lanes.
// - Big-endian word store, 8-bit bus: four cycles EA..EA+3, most significant first.
// - Big-endian halfword store, 8-bit bus: high byte at EA, low at EA+1.
// - Big-endian word load, 8-bit bus: four ascending reads assembled from the top.
// - Big-endian halfword load, 8-bit bus: two reads, replicated; byte load once.
// - Little-endian 32-bit bus: word store unchanged; halfword picks lower or upper half.
// - Little-endian byte store, 32-bit bus: byte offset selects external lane 0 to 3.
// - Little-endian 32-bit bus loads read one full word and select lanes internally.
// - Little-endian word store, 16-bit bus: upper half at EA+1 first, then lower.
// - Little-endian 16-bit bus: halfword one cycle; even bytes on 7:0, odd on 15:8.
// - Store data is replicated across halves or all byte lanes before steering.
package elb_pkg;

   // Access sizes as presented by the processor.
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;

   // External bus width codes, as carried by the width strap.
   localparam logic [1:0] BW_RSVD = 2'h0;
   localparam logic [1:0] BW_8 = 2'h1;
   localparam logic [1:0] BW_16 = 2'h2;
   localparam logic [1:0] BW_32 = 2'h3;

   // Active-low byte enable patterns.
   localparam logic [3:0] BE_NONE_B = 4'hf;
   localparam logic [3:0] BE_ALL_B = 4'h0;
   localparam logic [3:0] BE_LANE0_B = 4'he;
   localparam logic [3:0] BE_LANE1_B = 4'hd;
   localparam logic [3:0] BE_LO_B = 4'hc;
   localparam logic [3:0] BE_HI_B = 4'h3;
   localparam logic [3:0] BE_ONE = 4'h1;

   // Beat counter values and reset values.
   localparam logic [1:0] REM_ZERO = 2'h0;
   localparam logic [1:0] REM_ONE = 2'h1;
   localparam logic [1:0] REM_THREE = 2'h3;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0001;

   // Response buffer word: write flag above 32 data bits.
   localparam int RSP_W = 33;

   typedef enum logic [1:0] {ST_IDLE, ST_BEAT, ST_PUSH} elb_state_type;

   function automatic logic [15:0] swap16(input logic [15:0] h);
      swap16 = {h[7:0], h[15:8]};
   endfunction

   function automatic logic [31:0] swap32(input logic [31:0] w);
      swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   // Processor data bus form: halfwords on both halves, bytes on all lanes.
   function automatic logic [31:0] repl(input logic [31:0] r, input logic [1:0] size);
      case (size)
         SZ_WORD: repl = r;
         SZ_HALF: repl = {r[15:0], r[15:0]};
         default: repl = {4{r[7:0]}};
      endcase
   endfunction

   // A reserved width code is served as a full-width bus.
   function automatic logic [1:0] norm_width(input logic [1:0] w);
      norm_width = (w == BW_RSVD) ? BW_32 : w;
   endfunction

endpackage

// [design/elb_strap_sample.sv]
// Strap sampler: synchronises the endianness and bank 0 width pins and holds them after reset.
// Assumes the board holds both straps steady from before reset release until well after it.
`timescale 1ns/1ps
module elb_strap_sample (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Board pins
   input wire logic big_endian_strap,
   input wire logic [1:0] bank0_width_strap,
   // Captured values
   output logic big_endian,
   output logic [1:0] bank0_width,
   output logic straps_ready
);
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic [1:0] fill_ff;
   logic big_ff;
   logic [1:0] width_ff;
   logic taken_ff;
   wire sample_now = fill_ff[1] && !taken_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
         fill_ff <= 2'h0;
      end else begin
         sync1_ff <= {big_endian_strap, bank0_width_strap};
         sync2_ff <= sync1_ff;
         fill_ff <= {fill_ff[0], 1'b1};
      end
   end

   // The straps are caught once, after the synchroniser holds a real sample, and then frozen.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         big_ff <= 1'b0;
         width_ff <= elb_pkg::BW_32;
         taken_ff <= 1'b0;
      end else if (sample_now) begin
         big_ff <= sync2_ff[2];
         width_ff <= elb_pkg::norm_width(sync2_ff[1:0]);
         taken_ff <= 1'b1;
      end
   end

   assign big_endian = big_ff;
   assign bank0_width = width_ff;
   assign straps_ready = taken_ff;
endmodule

// [design/elb_rsp_buf.sv]
// Two-entry response buffer between the sequencer and the processor.
// Assumes both sides follow valid/ready: a word moves when both are high at a clock edge.
`timescale 1ns/1ps
module elb_rsp_buf #(
   parameter int WIDTH = 33
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] slot_ff [2];
   logic wr_ptr_ff;
   logic rd_ptr_ff;
   logic [1:0] count_ff;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count_ff != 2'h2);
   assign out_valid = (count_ff != 2'h0);
   assign out_data = slot_ff[rd_ptr_ff];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         slot_ff[0] <= '0;
         slot_ff[1] <= '0;
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         count_ff <= 2'h0;
      end else begin
         if (push) begin
            slot_ff[wr_ptr_ff] <= in_data;
            wr_ptr_ff <= !wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= !rd_ptr_ff;
         end
         count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// [verification/elb_ext_mem.sv]
// Behavioural external memory that answers each beat promptly or after a random stall.
// Assumes one clock shared with the block and one done pulse per beat.
`timescale 1ns/1ps
module elb_ext_mem (
   // Clock
   input wire logic clk_sys,
   // External cycle
   input wire logic ext_cyc,
   input wire logic ext_we_b,
   input wire logic [3:0] ext_be_b,
   input wire logic [31:0] ext_addr,
   input wire logic [31:0] ext_wdata,
   output logic ext_done,
   output logic [31:0] ext_rdata,
   // Observation
   output int beats,
   output logic [31:0] first_addr,
   output logic [7:0] first_byte
);
   logic [31:0] mem [256];
   logic fresh = 1'b1;
   int seed = 32'h8b42_349b;
   initial begin
      ext_done = 1'b0;
      ext_rdata = 32'h0000_0000;
      beats = 0;
   end
   // Read data toggles outside the done cycle so a late sample never looks valid.
   always @(posedge clk_sys) begin
      ext_rdata <= ~ext_rdata;
      if (ext_cyc !== 1'b1) fresh <= 1'b1;
      if (ext_cyc === 1'b1 && ext_done) begin
         for (int i = 0; i < 4; i++) if (!ext_we_b && !ext_be_b[i]) mem[ext_addr[7:0]][8*i+:8] <= ext_wdata[8*i+:8];
         beats <= fresh ? 1 : beats + 1;
         if (fresh) first_addr <= ext_addr;
         if (fresh) first_byte <= ext_wdata[7:0];
         fresh <= 1'b0;
         ext_done <= 1'b0;
      end else if (ext_cyc === 1'b1 && $random(seed) % 3 != 0) begin
         ext_done <= 1'b1;
         ext_rdata <= mem[ext_addr[7:0]];
      end
   end
endmodule

// [verification/elb_lane_steer_test.sv]
// Self-checking bench: store then load back over every width, size and byte order.
// Assumes the partner memory model and the response buffer inside the block.
`timescale 1ns/1ps
module elb_lane_steer_test;
   logic clk_sys, rst_b, big_endian_strap, req_valid, req_write, req_bank0, rsp_ready, hold;
   logic rsp_valid, req_ready, rsp_write, ext_cyc, ext_we_b, ext_done;
   logic [1:0] bank0_width_strap, req_size, bank_width, w;
   logic [3:0] ext_be_b;
   logic [7:0] first_byte;
   logic [31:0] req_addr, req_wdata, rsp_rdata, ext_addr, ext_wdata, ext_rdata, first_addr, rd, d, a;
   int beats, n, bad_count = 0, comparisons = 0, seed = 32'h8b42_349b;
   elb_lane_steer dut (.*);
   elb_ext_mem mem_model (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) rsp_ready <= hold ? 1'b0 : ($random(seed) % 4 != 0);
   function automatic int nbeats(input logic [1:0] wd, sz);
      return (wd == 2'h1) ? (sz == 2'h2 ? 4 : sz == 2'h1 ? 2 : 1) : (wd == 2'h2 && sz == 2'h2) ? 2 : 1;
   endfunction
   function automatic logic [31:0] spread(input logic [31:0] v, input logic [1:0] sz);
      return sz == 2'h2 ? v : sz == 2'h1 ? {2{v[15:0]}} : {4{v[7:0]}};
   endfunction
   function automatic logic [31:0] first_unit(input logic [31:0] ad, input logic [1:0] wd, sz, input logic b);
      logic [31:0] al;
      al = ad & ~((sz == 2'h2) ? 32'h0000_0003 : (sz == 2'h1) ? 32'h0000_0001 : 32'h0000_0000);
      return (al >> ((wd == 2'h1) ? 0 : (wd == 2'h2) ? 1 : 2)) + (b ? 0 : nbeats(wd, sz) - 1);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic xfer(input logic wr, input logic [1:0] sz, input logic [31:0] ad, wd, input bit pop);
      int k;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_write <= wr;
      req_size <= sz;
      req_addr <= ad;
      req_wdata <= wd;
      k = 0;
      do @(posedge clk_sys); while (req_ready !== 1'b1 && ++k < 200);
      req_valid <= 1'b0;
      while (pop && !(rsp_valid === 1'b1 && rsp_ready === 1'b1) && ++k < 400) @(posedge clk_sys);
      rd = rsp_rdata;
      if (k >= 400) bad_count++;
      if (pop) chk("rsp_write", {31'h0, wr}, {31'h0, rsp_write});
   endtask
   initial begin
      {rst_b, big_endian_strap, req_valid, req_write, req_bank0, rsp_ready, hold} = '0;
      {bank0_width_strap, req_size, bank_width, req_addr, req_wdata} = '0;
      for (int b = 1; b >= 0; b--) begin
         rst_b <= 1'b0;
         big_endian_strap <= b[0];
         bank0_width_strap <= b ? 2'h1 : 2'h2;
         repeat (12) @(posedge clk_sys);
         rst_b <= 1'b1;
         for (int k = 0; k < 4; k++) for (int s = 0; s < 3; s++) for (int t = 0; t < 2; t++) begin
            w = (k == 0) ? bank0_width_strap : k[1:0];
            req_bank0 <= (k == 0);
            // The reserved width code must behave as a full-width bus.
            bank_width <= (k == 3 && t == 1) ? 2'h0 : k[1:0];
            a = t ? ($random(seed) & 32'h0000_00ff) : 32'h0000_00fc;
            d = $random(seed);
            xfer(1'b1, s[1:0], a, d, 1);
            chk("store rdata", 32'h0000_0000, rd);
            chk("store beats", nbeats(w, s[1:0]), beats);
            chk("first unit", first_unit(a, w, s[1:0], b[0]), first_addr);
            if (w == 2'h1) chk("first byte", s == 2 ? d[31:24] : s == 1 ? d[15:8] : d[7:0], first_byte);
            xfer(1'b0, s[1:0], a, 32'h0000_0000, 1);
            chk("load beats", nbeats(w, s[1:0]), beats);
            chk("load data", spread(d, s[1:0]), rd);
         end
         $display("test byte order %0d done", b);
      end
      hold <= 1'b1;
      repeat (3) xfer(1'b1, 2'h2, 32'h0000_0010, d, 0);
      repeat (10) @(posedge clk_sys);
      chk("ready while full", 32'h0000_0000, {31'h0, req_ready});
      hold <= 1'b0;
      n = 0;
      repeat (80) @(posedge clk_sys) if (rsp_valid === 1'b1 && rsp_ready === 1'b1) n++;
      chk("drained", 3, n);
      $display("test buffer fill done");
      complete_run();
   end
   initial begin
      #(20000 * 10);
      bad_count++;
      complete_run();
   end
endmodule
